// File: aga_pkg.sv
// shared constants and types for the cpu address generation block
package aga_pkg;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] GPR_RESET = 8'h00;

  // ---------------------------------------------------------------
  // fixed address areas and the divide-by-zero quotient
  // ---------------------------------------------------------------
  localparam logic [15:0] GPR_BASE = 16'hfee0;
  localparam logic [4:0] FIX_CALL_PREFIX = 5'h01;
  localparam logic [15:0] VEC_BASE = 16'h0040;
  localparam logic [6:0] SADDR_PAGE = 7'h7f;
  localparam logic [7:0] SADDR_SPLIT = 8'h20;
  localparam logic [7:0] SFR_PAGE = 8'hff;
  localparam logic [3:0] SFR_HOLE = 4'hd;
  localparam logic [15:0] RAM_LO_DEF = 16'hfb00;
  localparam logic [15:0] RAM_HI_DEF = 16'hfeff;
  localparam logic [15:0] DIV_ZERO_QUOT = 16'hffff;

  // ---------------------------------------------------------------
  // register numbering inside a bank
  // ---------------------------------------------------------------
  localparam logic [2:0] REG_A = 3'h1;
  localparam logic [1:0] PAIR_AX = 2'h0;
  localparam logic [1:0] PAIR_HL = 2'h3;

  // ---------------------------------------------------------------
  // operation codes from the instruction decoder
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NEXT, OP_BR_REL, OP_BR_COND, OP_JMP_ABS, OP_JMP_AX,
    OP_CALL_ABS, OP_CALL_FIX, OP_CALL_TBL, OP_RET, OP_PUSH, OP_POP,
    OP_SP_LOAD, OP_BYTE_LOAD, OP_PAIR_LOAD, OP_UNSIGNED_MULTIPLY, OP_UNSIGNED_WORD_DIVIDE,
    OP_ADJ, OP_ROT4, OP_REG, OP_DIR, OP_SADDR, OP_SFR, OP_IND,
    OP_BASED, OP_BIDX
  } aga_op_t;

  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_PUSH_HI, S_PUSH_LO, S_POP_LO, S_POP_HI, S_VEC_LO, S_VEC_HI
  } aga_state_t;

  // what a multi-cycle sequence finishes with
  typedef enum logic [1:0] {
    K_PUSH, K_CALL, K_POP, K_RET
  } aga_kind_t;

endpackage

// File: aga_gpr_file.sv
// four banks of eight byte registers with byte and pair access
`timescale 1ns/1ps
module aga_gpr_file
  import aga_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bank choice
  input wire logic [1:0] bank_i,
  // byte write
  input wire logic byte_wr_i,
  input wire logic [2:0] byte_sel_i,
  input wire logic [7:0] byte_data_i,
  // pair write
  input wire logic pair_wr_i,
  input wire logic [1:0] pair_sel_i,
  input wire logic [15:0] pair_data_i,
  // reads
  input wire logic [2:0] rd_byte_sel_i,
  input wire logic [1:0] rd_pair_sel_i,
  output logic [7:0] rd_byte_o,
  output logic [15:0] rd_pair_o,
  output logic [7:0] acc_o,
  output logic [15:0] acc_pair_o,
  output logic [15:0] base_pair_o
);

  logic [7:0] regs_reg [0:31];
  logic [7:0] regs_next [0:31];

  // bank 0 sits at the top of the area, so the bank number is inverted
  function automatic logic [4:0] slot(input logic [1:0] bank, input logic [2:0] sel);
    slot = {~bank, sel};
  endfunction

  // ---------------------------------------------------------------
  // read side
  // ---------------------------------------------------------------
  assign rd_byte_o = regs_reg[slot(bank_i, rd_byte_sel_i)];
  assign rd_pair_o = {regs_reg[slot(bank_i, {rd_pair_sel_i, 1'b1})],
                      regs_reg[slot(bank_i, {rd_pair_sel_i, 1'b0})]};
  assign acc_o = regs_reg[slot(bank_i, REG_A)];
  assign acc_pair_o = {regs_reg[slot(bank_i, {PAIR_AX, 1'b1})],
                       regs_reg[slot(bank_i, {PAIR_AX, 1'b0})]};
  assign base_pair_o = {regs_reg[slot(bank_i, {PAIR_HL, 1'b1})],
                        regs_reg[slot(bank_i, {PAIR_HL, 1'b0})]};

  // ---------------------------------------------------------------
  // write side
  // ---------------------------------------------------------------
  // byte write applied after pair write so a divide's remainder lands last
  always_comb begin
    regs_next = regs_reg;
    if (pair_wr_i) begin
      regs_next[slot(bank_i, {pair_sel_i, 1'b0})] = pair_data_i[7:0];
      regs_next[slot(bank_i, {pair_sel_i, 1'b1})] = pair_data_i[15:8];
    end
    if (byte_wr_i) begin
      regs_next[slot(bank_i, byte_sel_i)] = byte_data_i;
    end
  end

  // register storage
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 32; i++) begin
      regs_reg[i] <= rst_i ? GPR_RESET : regs_next[i];
    end
  end

endmodule

// File: aga_addr_gen.sv
// cpu address generation: branch targets, operand addresses, stack access
//
// Contract
// - with no branch the program counter advances by the instruction length
// - relative target is next instruction address plus sign-extended byte
// - relative form serves the plain relative branch and all conditional branches
// - long call and long jump load the 16-bit immediate unchanged
// - fixed-area call target always lies in 0800H to 0FFFH
// - table call picks its vector with opcode field bits 1 to 5
// - table vectors are read from 40H to 7FH, target anywhere
// - register jump copies the accumulator pair into the program counter
// - multiply takes accumulator times named register, product to accumulator pair
// - word divide uses accumulator pair; adjust and digit rotate use accumulator
// - register operands come from the bank chosen by the two select flags
// - direct mode uses the 16-bit immediate as effective address
// - short direct maps its byte onto the window FE20H to FF1FH
// - short direct address bit 8 is set only for fields 00H to 1FH
// - special register mode reaches FF00H-FFCFH and FFE0H-FFFFH
// - register indirect uses pointer pair two or base pointer pair
// - based mode adds zero-extended offset to base pair, carry dropped
// - based indexed adds zero-extended index register to base pair, carry dropped
// - push, pop, call, return address memory through the stack pointer
// - stack pointer decrements before each write, increments after each read
// - general registers fill FEE0H to FEFFH as four banks of eight
`timescale 1ns/1ps
module aga_addr_gen
  import aga_pkg::*;
#(
  parameter logic [15:0] RAM_LO = RAM_LO_DEF,
  parameter logic [15:0] RAM_HI = RAM_HI_DEF
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // decoded instruction
  input wire logic op_valid_i,
  input wire aga_op_t op_i,
  input wire logic [2:0] op_len_i,
  input wire logic [15:0] imm16_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic [1:0] pair_sel_i,
  input wire logic word_i,
  input wire logic cond_i,
  // bank select flags
  input wire logic bank_select_low_i,
  input wire logic bank_select_high_i,
  // memory bus
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_ack_i,
  // status and results
  output logic [15:0] pc_o,
  output logic [15:0] sp_o,
  output logic [15:0] ea_o,
  output logic ea_valid_o,
  output logic [7:0] operand_o,
  output logic fault_o,
  output logic busy_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  aga_state_t state_reg, state_next;
  aga_kind_t kind_reg, kind_next;
  logic [15:0] pc_reg, pc_next;
  logic [15:0] sp_reg, sp_next;
  logic [15:0] target_reg, target_next;
  logic [15:0] word_reg, word_next;
  logic [1:0] pair_reg, pair_next;
  logic [15:0] ea_reg, ea_next;
  logic ea_valid_reg, ea_valid_next;
  logic [7:0] operand_reg, operand_next;
  logic fault_reg, fault_next;
  logic busy_reg, busy_next;
  logic [15:0] mem_addr_reg, mem_addr_next;
  logic mem_rd_reg, mem_rd_next;
  logic mem_wr_reg, mem_wr_next;
  logic [7:0] mem_wdata_reg, mem_wdata_next;

  // register file connections
  logic [1:0] bank;
  logic [1:0] rd_pair_sel;
  logic [7:0] gpr_byte, gpr_acc;
  logic [15:0] gpr_pair, gpr_acc_pair, gpr_base_pair;
  logic wr_byte_en, wr_pair_en;
  logic [2:0] wr_byte_sel;
  logic [1:0] wr_pair_sel;
  logic [7:0] wr_byte_data;
  logic [15:0] wr_pair_data;

  // address arithmetic
  logic [15:0] next_seq, rel_target, fix_target, vec_addr, saddr_ea;
  logic [15:0] product, quotient, remainder;
  logic push_go, pop_go;
  logic [15:0] push_word;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction

  // stack accesses outside internal ram are flagged, never blocked
  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= RAM_LO) && (a <= RAM_HI);
  endfunction

  // memory address of a general register in the current bank
  function automatic logic [15:0] gpr_addr(input logic [1:0] b, input logic [2:0] sel);
    gpr_addr = GPR_BASE + {11'h000, ~b, sel};
  endfunction

  assign bank = {bank_select_high_i, bank_select_low_i};
  // indirect mode only ever names pair two or the base pair
  assign rd_pair_sel = (op_i == OP_IND) ? {1'b1, pair_sel_i[0]} : pair_sel_i;

  // ---------------------------------------------------------------
  // general registers
  // ---------------------------------------------------------------
  aga_gpr_file u_gpr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bank_i(bank),
    .byte_wr_i(wr_byte_en),
    .byte_sel_i(wr_byte_sel),
    .byte_data_i(wr_byte_data),
    .pair_wr_i(wr_pair_en),
    .pair_sel_i(wr_pair_sel),
    .pair_data_i(wr_pair_data),
    .rd_byte_sel_i(reg_sel_i),
    .rd_pair_sel_i(rd_pair_sel),
    .rd_byte_o(gpr_byte),
    .rd_pair_o(gpr_pair),
    .acc_o(gpr_acc),
    .acc_pair_o(gpr_acc_pair),
    .base_pair_o(gpr_base_pair)
  );

  // ---------------------------------------------------------------
  // target and operand arithmetic
  // ---------------------------------------------------------------
  assign next_seq = pc_reg + {13'h0000, op_len_i};
  // 16-bit sum, carry out simply falls away
  assign rel_target = next_seq + sext8(imm16_i[7:0]);
  assign fix_target = {FIX_CALL_PREFIX, imm16_i[10:0]};
  assign vec_addr = VEC_BASE | {10'h000, imm16_i[5:1], 1'b0};
  assign saddr_ea = {SADDR_PAGE, (imm16_i[7:0] < SADDR_SPLIT), imm16_i[7:0]};
  assign product = {8'h00, gpr_acc} * {8'h00, gpr_byte};
  // divide by zero gives all ones and keeps the dividend low byte
  assign quotient = (gpr_byte == 8'h00) ? DIV_ZERO_QUOT : gpr_acc_pair / {8'h00, gpr_byte};
  assign remainder = (gpr_byte == 8'h00) ? gpr_acc_pair : gpr_acc_pair % {8'h00, gpr_byte};

  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    pc_next = pc_reg;
    sp_next = sp_reg;
    target_next = target_reg;
    word_next = word_reg;
    pair_next = pair_reg;
    ea_next = ea_reg;
    ea_valid_next = 1'b0;
    operand_next = operand_reg;
    fault_next = 1'b0;
    mem_addr_next = mem_addr_reg;
    mem_rd_next = mem_rd_reg;
    mem_wr_next = mem_wr_reg;
    mem_wdata_next = mem_wdata_reg;
    wr_byte_en = 1'b0;
    wr_byte_sel = reg_sel_i;
    wr_byte_data = imm16_i[7:0];
    wr_pair_en = 1'b0;
    wr_pair_sel = pair_sel_i;
    wr_pair_data = imm16_i;
    push_go = 1'b0;
    pop_go = 1'b0;
    push_word = next_seq;
    case (state_reg)
      S_IDLE: begin
        if (op_valid_i) begin
          pc_next = next_seq;
          case (op_i)
            OP_BR_REL: begin
              pc_next = rel_target;
            end
            OP_BR_COND: begin
              if (cond_i) begin
                pc_next = rel_target;
              end
            end
            OP_JMP_ABS: begin
              pc_next = imm16_i;
            end
            OP_JMP_AX: begin
              pc_next = gpr_acc_pair;
            end
            OP_CALL_ABS: begin
              kind_next = K_CALL;
              target_next = imm16_i;
              push_go = 1'b1;
            end
            OP_CALL_FIX: begin
              kind_next = K_CALL;
              target_next = fix_target;
              push_go = 1'b1;
            end
            OP_CALL_TBL: begin
              // vector is fetched first, the return address is pushed after
              kind_next = K_CALL;
              word_next = next_seq;
              mem_addr_next = vec_addr;
              mem_rd_next = 1'b1;
              state_next = S_VEC_LO;
            end
            OP_RET: begin
              kind_next = K_RET;
              pop_go = 1'b1;
            end
            OP_PUSH: begin
              kind_next = K_PUSH;
              push_word = gpr_pair;
              push_go = 1'b1;
            end
            OP_POP: begin
              kind_next = K_POP;
              pair_next = pair_sel_i;
              pop_go = 1'b1;
            end
            OP_SP_LOAD: begin
              sp_next = imm16_i;
            end
            OP_BYTE_LOAD: begin
              wr_byte_en = 1'b1;
            end
            OP_PAIR_LOAD: begin
              wr_pair_en = 1'b1;
            end
            OP_UNSIGNED_MULTIPLY: begin
              wr_pair_en = 1'b1;
              wr_pair_sel = PAIR_AX;
              wr_pair_data = product;
            end
            OP_UNSIGNED_WORD_DIVIDE: begin
              wr_pair_en = 1'b1;
              wr_pair_sel = PAIR_AX;
              wr_pair_data = quotient;
              wr_byte_en = 1'b1;
              wr_byte_data = remainder[7:0];
            end
            OP_ADJ, OP_ROT4: begin
              ea_next = gpr_addr(bank, REG_A);
              operand_next = gpr_acc;
              ea_valid_next = 1'b1;
            end
            OP_REG: begin
              ea_next = gpr_addr(bank, reg_sel_i);
              operand_next = gpr_byte;
              ea_valid_next = 1'b1;
            end
            OP_DIR: begin
              ea_next = imm16_i;
              ea_valid_next = 1'b1;
            end
            OP_SADDR: begin
              ea_next = saddr_ea;
              // odd word address is software's error, reported not served
              fault_next = word_i & imm16_i[0];
              ea_valid_next = ~(word_i & imm16_i[0]);
            end
            OP_SFR: begin
              ea_next = {SFR_PAGE, imm16_i[7:0]};
              // the unmapped FFDxH strip and odd word addresses are refused
              fault_next = (imm16_i[7:4] == SFR_HOLE) | (word_i & imm16_i[0]);
              ea_valid_next = ~((imm16_i[7:4] == SFR_HOLE) | (word_i & imm16_i[0]));
            end
            OP_IND: begin
              ea_next = gpr_pair;
              ea_valid_next = 1'b1;
            end
            OP_BASED: begin
              ea_next = gpr_base_pair + {8'h00, imm16_i[7:0]};
              ea_valid_next = 1'b1;
            end
            OP_BIDX: begin
              ea_next = gpr_base_pair + {8'h00, gpr_byte};
              ea_valid_next = 1'b1;
            end
            default: begin
              pc_next = next_seq;
            end
          endcase
        end
      end
      S_PUSH_HI: begin
        if (mem_ack_i) begin
          sp_next = sp_reg - 16'h0001;
          mem_addr_next = sp_reg - 16'h0001;
          mem_wdata_next = word_reg[7:0];
          fault_next = ~in_ram(sp_reg - 16'h0001);
          state_next = S_PUSH_LO;
        end
      end
      S_PUSH_LO: begin
        if (mem_ack_i) begin
          mem_wr_next = 1'b0;
          state_next = S_IDLE;
          if (kind_reg == K_CALL) begin
            pc_next = target_reg;
          end
        end
      end
      S_POP_LO: begin
        if (mem_ack_i) begin
          word_next = {word_reg[15:8], mem_rdata_i};
          sp_next = sp_reg + 16'h0001;
          mem_addr_next = sp_reg + 16'h0001;
          fault_next = ~in_ram(sp_reg + 16'h0001);
          state_next = S_POP_HI;
        end
      end
      S_POP_HI: begin
        if (mem_ack_i) begin
          sp_next = sp_reg + 16'h0001;
          mem_rd_next = 1'b0;
          state_next = S_IDLE;
          if (kind_reg == K_RET) begin
            pc_next = {mem_rdata_i, word_reg[7:0]};
          end else begin
            wr_pair_en = 1'b1;
            wr_pair_sel = pair_reg;
            wr_pair_data = {mem_rdata_i, word_reg[7:0]};
          end
        end
      end
      S_VEC_LO: begin
        if (mem_ack_i) begin
          target_next = {target_reg[15:8], mem_rdata_i};
          mem_addr_next = mem_addr_reg + 16'h0001;
          state_next = S_VEC_HI;
        end
      end
      S_VEC_HI: begin
        if (mem_ack_i) begin
          target_next = {mem_rdata_i, target_reg[7:0]};
          push_word = word_reg;
          push_go = 1'b1;
        end
      end
      default: begin
        state_next = S_IDLE;
        mem_rd_next = 1'b0;
        mem_wr_next = 1'b0;
      end
    endcase
    // push opens with the high byte, pointer dropped before the write
    if (push_go) begin
      sp_next = sp_reg - 16'h0001;
      mem_addr_next = sp_reg - 16'h0001;
      mem_wr_next = 1'b1;
      mem_rd_next = 1'b0;
      mem_wdata_next = push_word[15:8];
      word_next = push_word;
      fault_next = ~in_ram(sp_reg - 16'h0001);
      state_next = S_PUSH_HI;
    end
    // pop reads at the pointer, raised only after the read
    if (pop_go) begin
      mem_addr_next = sp_reg;
      mem_rd_next = 1'b1;
      fault_next = ~in_ram(sp_reg);
      state_next = S_POP_LO;
    end
    busy_next = (state_next != S_IDLE);
  end

  // ---------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      kind_reg <= K_PUSH;
      pc_reg <= PC_RESET;
      sp_reg <= SP_RESET;
      target_reg <= PC_RESET;
      word_reg <= 16'h0000;
      pair_reg <= PAIR_AX;
      ea_reg <= 16'h0000;
      ea_valid_reg <= 1'b0;
      operand_reg <= 8'h00;
      fault_reg <= 1'b0;
      busy_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_wdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      pc_reg <= pc_next;
      sp_reg <= sp_next;
      target_reg <= target_next;
      word_reg <= word_next;
      pair_reg <= pair_next;
      ea_reg <= ea_next;
      ea_valid_reg <= ea_valid_next;
      operand_reg <= operand_next;
      fault_reg <= fault_next;
      busy_reg <= busy_next;
      mem_addr_reg <= mem_addr_next;
      mem_rd_reg <= mem_rd_next;
      mem_wr_reg <= mem_wr_next;
      mem_wdata_reg <= mem_wdata_next;
    end
  end

  // outputs straight from flops
  assign pc_o = pc_reg;
  assign sp_o = sp_reg;
  assign ea_o = ea_reg;
  assign ea_valid_o = ea_valid_reg;
  assign operand_o = operand_reg;
  assign fault_o = fault_reg;
  assign busy_o = busy_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_rd_o = mem_rd_reg;
  assign mem_wr_o = mem_wr_reg;
  assign mem_wdata_o = mem_wdata_reg;

endmodule

// File: aga_addr_gen_properties.sv
// concurrent checks on the address generation ports
`timescale 1ns/1ps
module aga_addr_gen_properties
  import aga_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // decoder side
  input wire logic op_valid_i,
  input wire aga_op_t op_i,
  input wire logic [2:0] op_len_i,
  input wire logic [15:0] imm16_i,
  input wire logic word_i,
  input wire logic cond_i,
  // memory and status side
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_wr_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] pc_o,
  input wire logic [15:0] sp_o,
  input wire logic [15:0] ea_o,
  input wire logic ea_valid_o,
  input wire logic fault_o,
  input wire logic busy_o
);
  // ---------------------------------------------------------------
  // expected addresses, worked out from the inputs
  // ---------------------------------------------------------------
  logic tk;
  logic [15:0] nxt;
  logic [15:0] rel;
  logic [15:0] sad;
  logic [15:0] sfa;
  assign tk = op_valid_i && !busy_o;
  assign nxt = pc_o + 16'(op_len_i);
  assign rel = nxt + {{8{imm16_i[7]}}, imm16_i[7:0]};
  assign sad = {7'h7f, imm16_i[7:0] < 8'h20, imm16_i[7:0]};
  assign sfa = {8'hff, imm16_i[7:0]};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_pc_advance: assert property (
    tk && (op_i == OP_NEXT || op_i == OP_BR_COND && !cond_i) |=> pc_o == $past(nxt))
    else $error("pc did not step by length");
  a_rel_target: assert property (
    tk && (op_i == OP_BR_REL || op_i == OP_BR_COND && cond_i) |=> pc_o == $past(rel))
    else $error("relative target wrong");
  a_abs_jump: assert property (
    tk && op_i == OP_JMP_ABS |=> pc_o == $past(imm16_i)) else $error("long jump wrong");
  a_direct_ea: assert property (
    tk && op_i == OP_DIR |=> ea_valid_o && ea_o == $past(imm16_i)) else $error("direct ea");
  a_short_window: assert property (
    tk && op_i == OP_SADDR && !word_i |=> ea_valid_o && ea_o == $past(sad))
    else $error("short direct ea wrong");
  a_sfr_map: assert property (
    tk && op_i == OP_SFR && !word_i && imm16_i[7:4] != 4'hd |=> ea_o == $past(sfa))
    else $error("sfr ea wrong");
  a_sfr_hole: assert property (
    tk && op_i == OP_SFR && imm16_i[7:4] == 4'hd |=> fault_o && !ea_valid_o)
    else $error("sfr hole accepted");
  a_stack_predec: assert property (
    mem_wr_o |-> mem_addr_o == sp_o) else $error("stack write not at new sp");
  a_busy_bound: assert property (
    $rose(busy_o) |-> ##[1:60] !busy_o) else $error("stack sequence hung");
  // main scenarios reached
  cover property (tk && op_i == OP_CALL_TBL);
  cover property (fault_o);
  cover property (mem_wr_o && mem_ack_i);
endmodule

bind aga_addr_gen aga_addr_gen_properties u_props (.clk_i, .rst_i, .op_valid_i, .op_i,
  .op_len_i, .imm16_i, .word_i, .cond_i, .mem_addr_o, .mem_wr_o, .mem_ack_i, .pc_o,
  .sp_o, .ea_o, .ea_valid_o, .fault_o, .busy_o);

// File: aga_mem_model.sv
// byte memory on the far side of the address bus
`timescale 1ns/1ps
module aga_mem_model (
  // clock
  input wire logic clk_i,
  // request
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [2:0] wait_i,
  // answer
  output logic [7:0] rdata_o = 8'h00,
  output logic ack_o = 1'b0
);
  // ---------------------------------------------------------------
  // storage and wait counter
  // ---------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic [2:0] cnt = 3'h0;
  // ack after wait_i idle cycles; read data toggles outside ack so stale data never matches
  always @(posedge clk_i) begin
    if ((rd_i || wr_i) && !ack_o && cnt >= wait_i) begin
      ack_o <= 1'b1;
      rdata_o <= mem[addr_i];
      cnt <= 3'h0;
      if (wr_i) begin
        mem[addr_i] <= wdata_i;
      end
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      cnt <= ((rd_i || wr_i) && !ack_o) ? cnt + 3'h1 : 3'h0;
    end
  end
endmodule

// File: aga_addr_gen_tb.sv
// self-checking testbench for the address generation block
`timescale 1ns/1ps
module aga_addr_gen_tb
  import aga_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic clk_i = 0, rst_i = 1, op_valid_i = 0, word_i = 0, cond_i = 1;
  logic [1:0] bank = 2'h0;
  aga_op_t op_i = OP_NEXT;
  logic [15:0] imm16_i = 16'h0000;
  logic [2:0] reg_sel_i = 3'h0, wt = 3'h0, len = 3'h2;
  logic [15:0] mem_addr_o, pc_o, sp_o, ea_o;
  logic mem_rd_o, mem_wr_o, mem_ack_i, ea_valid_o, fault_o, busy_o;
  logic [7:0] mem_wdata_o, mem_rdata_i, operand_o;
  int err_count = 0, total_checks = 0, cyc = 0;

  aga_addr_gen dut (.clk_i, .rst_i, .op_valid_i, .op_i, .op_len_i(len), .imm16_i,
    .reg_sel_i, .pair_sel_i(reg_sel_i[1:0]), .word_i, .cond_i, .bank_select_low_i(bank[0]),
    .bank_select_high_i(bank[1]), .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o,
    .mem_rdata_i, .mem_ack_i, .pc_o, .sp_o, .ea_o, .ea_valid_o, .operand_o, .fault_o,
    .busy_o);
  aga_mem_model u_mem (.clk_i, .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .wdata_i(mem_wdata_o), .wait_i(wt), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

  // clock and hang guard
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // one op, taken at the next edge, then wait out any stack sequence
  task automatic op(aga_op_t o, logic [15:0] im, logic [2:0] rs = 3'h0);
    int n;
    @(posedge clk_i);
    #1 op_i = o;
    imm16_i = im;
    reg_sel_i = rs;
    op_valid_i = 1;
    @(posedge clk_i);
    #1 op_valid_i = 0;
    for (n = 0; n < 60 && busy_o !== 1'b0; n++) begin
      @(posedge clk_i);
      #1;
    end
  endtask

  task automatic t_branch();
    op(OP_NEXT, 16'h0000); chk(pc_o, 16'h0002);
    op(OP_BR_REL, 16'h0080); chk(pc_o, 16'hff84);
    cond_i = 0;
    op(OP_BR_COND, 16'h007f); chk(pc_o, 16'hff86);
    cond_i = 1;
    op(OP_BR_COND, 16'h007f); chk(pc_o, 16'h0007);
    len = 3'h3;
    op(OP_NEXT, 16'h0000); chk(pc_o, 16'h000a);
    len = 3'h2;
    op(OP_JMP_ABS, 16'hbeef); chk(pc_o, 16'hbeef);
  endtask

  task automatic t_calls();
    op(OP_SP_LOAD, 16'hfe00);
    op(OP_CALL_FIX, 16'hf123); chk(pc_o, 16'h0923);
    chk({u_mem.mem[16'hfdff], u_mem.mem[16'hfdfe]}, 16'hbef3);
    op(OP_RET, 16'h0000); chk(pc_o, 16'hbef3);
    chk(sp_o, 16'hfe00);
    wt = 3'h3;
    u_mem.mem[16'h007e] = 8'h34;
    u_mem.mem[16'h007f] = 8'h12;
    op(OP_CALL_TBL, 16'h003e); chk(pc_o, 16'h1234);
    chk({u_mem.mem[16'hfdff], u_mem.mem[16'hfdfe]}, 16'hbef5);
    op(OP_CALL_ABS, 16'h5a5a); chk(pc_o, 16'h5a5a);
    chk({u_mem.mem[16'hfdfd], u_mem.mem[16'hfdfc]}, 16'h1236);
    chk(sp_o, 16'hfdfc);
  endtask

  task automatic t_regs();
    bank = 2'h2;
    op(OP_PAIR_LOAD, 16'h1234, 3'h0);
    op(OP_REG, 16'h0000, 3'h1); chk(ea_o, 16'hfee9);
    chk(16'(operand_o), 16'h0012);
    op(OP_JMP_AX, 16'h0000); chk(pc_o, 16'h1234);
    bank = 2'h0;
    op(OP_REG, 16'h0000, 3'h1); chk(ea_o, 16'hfef9);
    chk(16'(operand_o), 16'h0000);
    op(OP_BYTE_LOAD, 16'h00ff, 3'h1);
    op(OP_BYTE_LOAD, 16'h0080, 3'h2);
    op(OP_ADJ, 16'h0000); chk(ea_o, 16'hfef9);
    chk(16'(operand_o), 16'h00ff);
    op(OP_ROT4, 16'h0000); chk(16'(operand_o), 16'h00ff);
    op(OP_UNSIGNED_MULTIPLY, 16'h0000, 3'h2);
    op(OP_JMP_AX, 16'h0000); chk(pc_o, 16'h7f80);
    op(OP_UNSIGNED_WORD_DIVIDE, 16'h0000, 3'h2);
    op(OP_JMP_AX, 16'h0000); chk(pc_o, 16'h00ff);
  endtask

  task automatic t_modes();
    op(OP_DIR, 16'hfe00); chk(ea_o, 16'hfe00);
    op(OP_SADDR, 16'h0020); chk(ea_o, 16'hfe20);
    op(OP_SADDR, 16'h001f); chk(ea_o, 16'hff1f);
    word_i = 1;
    op(OP_SADDR, 16'h0021); chk(16'({ea_valid_o, fault_o}), 16'h0001);
    op(OP_SFR, 16'h00e4); chk(16'({ea_valid_o, fault_o}), 16'h0002);
    op(OP_SFR, 16'h00e5); chk(16'({ea_valid_o, fault_o}), 16'h0001);
    word_i = 0;
    op(OP_SFR, 16'h00d5); chk(16'({ea_valid_o, fault_o}), 16'h0001);
    op(OP_SFR, 16'h00e0); chk(ea_o, 16'hffe0);
    op(OP_PAIR_LOAD, 16'hffff, 3'h3);
    op(OP_PAIR_LOAD, 16'h4321, 3'h2);
    op(OP_BYTE_LOAD, 16'h0080, 3'h2);
    op(OP_BASED, 16'h0005); chk(ea_o, 16'h0004);
    op(OP_BIDX, 16'h0000, 3'h2); chk(ea_o, 16'h007f);
    op(OP_IND, 16'h0000, 3'h1); chk(ea_o, 16'hffff);
    op(OP_IND, 16'h0000, 3'h0); chk(ea_o, 16'h4321);
    op(OP_PUSH, 16'h0000, 3'h2);
    op(OP_POP, 16'h0000, 3'h0);
    op(OP_JMP_AX, 16'h0000); chk(pc_o, 16'h4321);
  endtask

  // reset, then the scenarios in order
  initial begin
    repeat (16) @(posedge clk_i);
    #1 rst_i = 0;
    t_branch();
    t_calls();
    t_regs();
    t_modes();
    give_verdict();
  end
endmodule
